// *** hdl/fsl_top.sv ***
// Sticky fault and event status latches with an AXI4-Lite register slave
// Contract
// - Checksum mismatch sets bit 4, sticky, resets.
// - Checksum flag reads zero while disabled.
// - Interrupt pin fault bit 3; clear after removal.
// - Thermal shutdown bit 2, enabled; clear after removal.
// - Rail tag fault bit 1, enabled; clear after removal.
// - Packet check fault bit 0; sets per transaction.
// - Single corrected load error bit 3, enabled.
// - Double load error bit 2, always enabled.
// - Self-test done bit 1, enabled.
// - Self-test fault bit 0, enabled.
// - Startup checksum fault sets internal bit 7.
// - Regulator fault sets internal bit 6.
// - Reset readback mismatch bit 5; clear after removal.
// - Oscillator fault sets internal bit 4.
// - Address pin short bit 3, open bit 2.
//
// Register access over AXI4-Lite was left to the implementer.
module fsl_top
	import fsl_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Detector inputs
	input  wire fsl_events_t events,
	// Interrupt outputs
	output logic             interrupt_out_low,
	output logic             irq,
	// AXI4-Lite write address and data
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// Register map, word index and byte address
	//   0x22 at 0x88  control and communication flags
	//   0x23 at 0x8C  self-test and configuration load flags
	//   0x24 at 0x90  internal fault flags
	//   0x25 at 0x94  flag enables
	//   0x26 at 0x98  interrupt mask, one bit per flag
	//   0x27 at 0x9C  live detector inputs, read only
	//   all other indexes answer with a slave error
	// Address bits above bit 9 are ignored, so the map aliases
	// Control and communication flags
	//   bit 4  runtime checksum mismatch, enabled
	//   bit 3  interrupt pin fault, no enable
	//   bit 2  thermal shutdown, enabled
	//   bit 1  rail tag pin fault, enabled
	//   bit 0  packet check fault, no enable
	// Self-test and configuration load flags
	//   bit 3  single error corrected, enabled
	//   bit 2  double error detected, no enable
	//   bit 1  self-test done, enabled
	//   bit 0  self-test fault, enabled
	// Internal fault flags, none has an enable
	//   bit 7  startup checksum fault
	//   bit 6  regulator fault
	//   bit 5  reset output readback mismatch
	//   bit 4  oscillator fault
	//   bit 3  address pin short
	//   bit 2  address pin open
	// Enable bits
	//   bit 0 checksum, 1 thermal, 2 rail tag,
	//   bit 3 single error, 4 self-test done, 5 self-test fault
	// Mask bytes: 7:0 control, 15:8 self-test, 23:16 internal
	// A flag set by its event at one edge is readable the next;
	// a set and a clear in the same cycle leave the flag set
	// Only byte lane 0 reaches the flags and the enables
	// Stored checksum flag survives while its enable is off
	// Reserved bits read zero; writes to them are dropped

	// Word index of a byte address
	function automatic logic [7:0] word_index(input logic [31:0] addr);
		word_index = addr[9:2];
	endfunction

	// Next value of a write-one-to-clear byte; a set in the same cycle
	// as a clear wins, held bits ignore the clear, reserved bits stay 0
	function automatic logic [7:0] w1c_next(
		input logic [7:0] cur,
		input logic [7:0] set,
		input logic [7:0] clr,
		input logic [7:0] hold,
		input logic [7:0] valid
	);
		w1c_next = (set | (cur & ~(clr & ~hold))) & valid;
	endfunction

	// Status, enable and mask storage
	logic [7:0]  ctrl_reg;
	logic [7:0]  test_reg;
	logic [7:0]  fault_reg;
	logic [7:0]  enable_reg;
	logic [23:0] mask_reg;
	logic [7:0]  ctrl_next;
	logic [7:0]  test_next;
	logic [7:0]  fault_next;

	// Write channel capture, write and read response state
	logic        aw_held_reg;
	logic [7:0]  aw_idx_reg;
	logic        w_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;

	// Handshake terms
	wire aw_take = s_axi_awvalid && !aw_held_reg && !bvalid_reg;
	wire w_take  = s_axi_wvalid && !w_held_reg && !bvalid_reg;
	wire wr_go   = aw_held_reg && w_held_reg && !bvalid_reg;
	wire ar_take = s_axi_arvalid && !rvalid_reg;
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready  = !w_held_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// Write decode; only byte lane 0 carries status clears
	wire        lane0    = wr_go && w_strb_reg[0];
	wire [7:0]  wbyte    = w_data_reg[7:0];
	wire        wr_ctrl  = lane0 && (aw_idx_reg == IDX_CTRL_COMM);
	wire        wr_test  = lane0 && (aw_idx_reg == IDX_TEST_LOAD);
	wire        wr_fault = lane0 && (aw_idx_reg == IDX_INT_FAULT);
	wire        wr_en    = lane0 && (aw_idx_reg == IDX_ENABLE);
	wire        wr_mask  = wr_go && (aw_idx_reg == IDX_MASK);
	wire        wr_known = (aw_idx_reg >= IDX_CTRL_COMM)
		&& (aw_idx_reg <= IDX_LIVE);

	wire [7:0] clr_ctrl  = wr_ctrl ? (wbyte & CTRL_COMM_MASK) : 8'h00;
	wire [7:0] clr_test  = wr_test ? (wbyte & TEST_LOAD_MASK) : 8'h00;
	wire [7:0] clr_fault = wr_fault ? (wbyte & INT_FAULT_MASK) : 8'h00;

	// Condition inputs that block a clear while high
	// Clear blocked while pin fault stays
	wire hold_int_pin  = events.interrupt_pin_fault;
	wire hold_thermal  = events.thermal_shutdown_fault;
	// Clear blocked while rail tag fault stays
	wire hold_rail_tag = events.rail_tag_fault;
	wire hold_readback = events.reset_out_readback_fault;
	wire [7:0] hold_ctrl  = {4'h0, hold_int_pin, hold_thermal,
		hold_rail_tag, 1'b0};
	wire [7:0] hold_fault = {2'h0, hold_readback, 5'h00};

	// Enable bits by name
	wire en_rt_crc   = enable_reg[EN_RT_CRC_BIT];
	wire en_thermal  = enable_reg[EN_TSD_BIT];
	wire en_rail_tag = enable_reg[EN_RAIL_TAG_BIT];
	wire en_single   = enable_reg[EN_SINGLE_BIT];
	wire en_st_done  = enable_reg[EN_SELF_TEST_FAULT_C_BIT];
	wire en_st_fault = enable_reg[EN_SELF_TEST_FAULT_F_BIT];

	// Control and communication set terms
	// Mismatch sets checksum flag
	wire set_crc      = events.checksum_mismatch && en_rt_crc;
	wire set_int_pin  = events.interrupt_pin_fault;
	wire set_thermal  = events.thermal_shutdown_fault && en_thermal;
	wire set_rail_tag = events.rail_tag_fault && en_rail_tag;
	wire set_packet   = events.packet_check_fault;

	// Self-test and load set terms
	// Single corrected error, enabled
	wire set_single   = events.config_single_corrected && en_single;
	wire set_double   = events.config_double_detected;
	wire set_st_done  = events.self_test_done && en_st_done;
	wire set_st_fault = events.self_test_fault && en_st_fault;

	// Internal fault set terms; none has an enable
	// Startup checksum fault
	wire set_startup    = events.startup_crc_fault;
	wire set_regulator  = events.regulator_fault;
	wire set_readback   = events.reset_out_readback_fault;
	wire set_osc        = events.oscillator_fault;
	wire set_addr_short = events.addr_pin_short_fault;
	wire set_addr_open  = events.addr_pin_open_fault;

	// Set vectors in register bit order
	wire [7:0] set_ctrl  = {3'h0, set_crc, set_int_pin, set_thermal,
		set_rail_tag, set_packet};
	wire [7:0] set_test  = {4'h0, set_single, set_double, set_st_done,
		set_st_fault};
	wire [7:0] set_fault = {set_startup, set_regulator, set_readback,
		set_osc, set_addr_short, set_addr_open, 2'h0};

	// Next status through the shared clear rule
	assign ctrl_next  = w1c_next(ctrl_reg, set_ctrl, clr_ctrl, hold_ctrl,
		CTRL_COMM_MASK);
	assign test_next  = w1c_next(test_reg, set_test, clr_test, 8'h00,
		TEST_LOAD_MASK);
	assign fault_next = w1c_next(fault_reg, set_fault, clr_fault,
		hold_fault, INT_FAULT_MASK);

	// Visible checksum flag is zero while disabled
	wire [7:0] ctrl_view = enable_reg[EN_RT_CRC_BIT] ? ctrl_reg
		: (ctrl_reg & ~8'h10);

	// Any unmasked visible flag asserts interrupt
	wire [7:0] pend_ctrl  = ctrl_view & mask_reg[7:0];
	wire [7:0] pend_test  = test_reg & mask_reg[15:8];
	wire [7:0] pend_fault = fault_reg & mask_reg[23:16];
	assign irq = |{pend_fault, pend_test, pend_ctrl};
	assign interrupt_out_low = ~irq;

	// Read decode
	wire [7:0] ar_idx = word_index(s_axi_araddr);
	wire [31:0] live_word = {17'h0, events[14:0]};
	// Read words, status and enable in the low byte
	wire [31:0] rd_ctrl   = {24'h0, ctrl_view};
	wire [31:0] rd_test   = {24'h0, test_reg};
	wire [31:0] rd_fault  = {24'h0, fault_reg};
	wire [31:0] rd_enable = {24'h0, enable_reg};
	wire [31:0] rd_mask   = {8'h0, mask_reg};
	wire        rd_known = (ar_idx >= IDX_CTRL_COMM) && (ar_idx <= IDX_LIVE);
	logic [31:0] rd_mux;
	always_comb
	begin
		case (ar_idx)
			IDX_CTRL_COMM: rd_mux = rd_ctrl;
			IDX_TEST_LOAD: rd_mux = rd_test;
			IDX_INT_FAULT: rd_mux = rd_fault;
			IDX_ENABLE:    rd_mux = rd_enable;
			IDX_MASK:      rd_mux = rd_mask;
			IDX_LIVE:      rd_mux = live_word;
			default:       rd_mux = 32'h0;
		endcase
	end

	// Status latches
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			ctrl_reg  <= STATUS_RESET;
			test_reg  <= STATUS_RESET;
			fault_reg <= STATUS_RESET;
		end
		else
		begin
			ctrl_reg  <= ctrl_next;
			test_reg  <= test_next;
			fault_reg <= fault_next;
		end
	end

	// Enable register, byte lane 0 only
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			enable_reg <= ENABLE_RESET;
		else if (wr_en)
			enable_reg <= wbyte & 8'h3F;
	end

	// Interrupt mask, per byte lane
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			mask_reg <= MASK_RESET;
		else if (wr_mask)
		begin
			if (w_strb_reg[0]) mask_reg[7:0]   <= w_data_reg[7:0];
			if (w_strb_reg[1]) mask_reg[15:8]  <= w_data_reg[15:8];
			if (w_strb_reg[2]) mask_reg[23:16] <= w_data_reg[23:16];
		end
	end

	// Write address capture; released once the write executes
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			aw_held_reg <= 1'b0;
			aw_idx_reg  <= 8'h00;
		end
		else if (aw_take)
		begin
			aw_held_reg <= 1'b1;
			aw_idx_reg  <= word_index(s_axi_awaddr);
		end
		else if (wr_go)
			aw_held_reg <= 1'b0;
	end

	// Write data capture; released once the write executes
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			w_held_reg <= 1'b0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
		end
		else if (w_take)
		begin
			w_held_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end
		else if (wr_go)
			w_held_reg <= 1'b0;
	end

	// Write response; stands until the master accepts it
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_known ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bvalid_reg && s_axi_bready)
			bvalid_reg <= 1'b0;
	end

	// Read response
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0;
			rresp_reg  <= RESP_OKAY;
		end
		else if (ar_take)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_mux;
			rresp_reg  <= rd_known ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_reg && s_axi_rready)
			rvalid_reg <= 1'b0;
	end

endmodule

// *** inc/fsl_pkg.sv ***
// Package for the fault status latch block: offsets, fields and types
package fsl_pkg;

	// Printed offsets are not multiples of four: these are word indexes
	localparam logic [7:0] IDX_CTRL_COMM = 8'h22;
	localparam logic [7:0] IDX_TEST_LOAD = 8'h23;
	localparam logic [7:0] IDX_INT_FAULT = 8'h24;
	// Enable register and interrupt mask, one word each
	localparam logic [7:0] IDX_ENABLE    = 8'h25;
	localparam logic [7:0] IDX_MASK      = 8'h26;
	localparam logic [7:0] IDX_LIVE      = 8'h27;

	// Valid bit masks of the three status registers
	localparam logic [7:0] CTRL_COMM_MASK = 8'h1F;
	localparam logic [7:0] TEST_LOAD_MASK = 8'h0F;
	localparam logic [7:0] INT_FAULT_MASK = 8'hFC;

	// Enable register field positions
	localparam int EN_RT_CRC_BIT   = 0;
	localparam int EN_TSD_BIT      = 1;
	localparam int EN_RAIL_TAG_BIT = 2;
	localparam int EN_SINGLE_BIT   = 3;
	localparam int EN_SELF_TEST_FAULT_C_BIT   = 4;
	localparam int EN_SELF_TEST_FAULT_F_BIT   = 5;

	// Reset values
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h3F;
	localparam logic [23:0] MASK_RESET  = 24'hFFFFFF;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Fault and event detector inputs, one-cycle pulses or levels
	typedef struct packed {
		logic checksum_mismatch;   // pulse at a runtime checksum check
		logic interrupt_pin_fault; // level
		logic thermal_shutdown_fault; // level
		logic rail_tag_fault;      // level
		logic packet_check_fault;  // pulse per serial transaction
		logic config_single_corrected; // pulse at config load
		logic config_double_detected;  // pulse at config load
		logic self_test_done;      // pulse at self-test end
		logic self_test_fault;     // pulse at self-test end
		logic startup_crc_fault;   // pulse
		logic regulator_fault;     // pulse or level
		logic reset_out_readback_fault; // level
		logic oscillator_fault;    // pulse or level
		logic addr_pin_short_fault; // pulse or level
		logic addr_pin_open_fault;  // pulse or level
	} fsl_events_t;

endpackage

// *** testbench/fsl_host.sv ***
// Host model: bus master that reads and clears status registers
module fsl_host (
	// Clock
	input wire logic   clk,
	// Requests
	output logic [31:0] addr,
	output logic [31:0] wdata,
	output logic        awv,
	output logic        wv,
	output logic        br,
	output logic        arv,
	output logic        rr,
	// Answers
	input wire logic        awr,
	input wire logic        wrd,
	input wire logic        bv,
	input wire logic [1:0]  bresp,
	input wire logic        arr,
	input wire logic        rv,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		{addr, wdata, awv, wv, br, arv, rr} = '0;
	end
	// A hung bus ends the run
	task automatic hang();
		$display("CHECK FAILED %0t bus timeout", $time);
		tb_top.errors++;
		tb_top.results();
	endtask
	// Address and data together; answer accepted one cycle late
	task automatic wr(input logic [31:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		addr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge clk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wrd)
				wv <= 1'b0;
			if (bv)
				break;
		end
		if (n == 100)
			hang();
		br <= 1'b1;
		@(posedge clk);
		r = bresp;
		br <= 1'b0;
	endtask
	// Read with a stalled accept of the answer
	task automatic rd(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		addr <= a;
		arv <= 1'b1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge clk);
			if (arv && arr)
				arv <= 1'b0;
			if (rv)
				break;
		end
		if (n == 100)
			hang();
		rr <= 1'b1;
		@(posedge clk);
		d = rdata;
		r = rresp;
		rr <= 1'b0;
	endtask
endmodule

// *** testbench/fsl_props.sv ***
// Checker: interrupt level and register bus timing at the block ports
module fsl_props
	import fsl_pkg::*;
(
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_n,
	// Detectors and interrupts
	input wire fsl_events_t events,
	input wire logic        interrupt_out_low,
	input wire logic        irq,
	// Bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Write taken on both channels, answer two edges later
	sequence s_wtake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wans;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	property p_wr;
		s_wtake |=> s_wans;
	endproperty
	property p_rd;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && !s_axi_awready;
	endproperty
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
	endproperty
	property p_arbusy;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	property p_inv;
		interrupt_out_low == !irq;
	endproperty
	property p_rst;
		$rose(rst_n) |-> !irq && !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	property p_pin;
		irq && events.interrupt_pin_fault |=> irq;
	endproperty
	a_wr: assert property (p_wr)
		else $error("write answer late or early");
	a_rd: assert property (p_rd)
		else $error("read answer missing");
	a_bhold: assert property (p_bhold)
		else $error("write answer dropped");
	a_rhold: assert property (p_rhold)
		else $error("read answer dropped");
	a_arbusy: assert property (p_arbusy)
		else $error("read taken while answer pending");
	a_inv: assert property (p_inv)
		else $error("interrupt pins disagree");
	a_rst: assert property (p_rst)
		else $error("state not idle after reset");
	a_pin: assert property (p_pin)
		else $error("interrupt fell while pin fault held");
endmodule
bind fsl_top fsl_props i_props (.ref_clk(ref_clk), .rst_n(rst_n),
	.events(events), .interrupt_out_low(interrupt_out_low), .irq(irq),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// *** testbench/tb_top.sv ***
// Bench: detector bursts and register cycles against a status model
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import fsl_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	fsl_events_t ev = '0;
	logic [31:0] addr, wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic        awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, irq, irq_n;
	int          errors = 0;
	int          check_count = 0;
	int          seed = 23396;
	logic [7:0]  m [3] = '{default: 8'h00};
	logic [5:0]  en = 6'h3F;
	logic [23:0] msk = 24'hFFFFFF;
	int          eb [15] = '{-1, -1, -1, -1, -1, -1, 5, 4, -1, 3, -1, 2, 1, -1, 0};
	initial forever #12.5 ref_clk = ~ref_clk;
	fsl_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .events(ev),
		.interrupt_out_low(irq_n), .irq(irq), .s_axi_awaddr(addr),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(addr), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rr));
	fsl_host i_host (.clk(ref_clk), .addr(addr), .wdata(wdata), .awv(awv),
		.wv(wv), .br(br), .arv(arv), .rr(rr), .awr(awr), .wrd(wrd), .bv(bv),
		.bresp(bresp), .arr(arr), .rv(rv), .rdata(rdata), .rresp(rresp));
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x)
		begin
			errors++;
			$display("CHECK FAILED %0t seen %h want %h", $time, s, x);
		end
	endtask
	// Expected read view; checksum flag hidden while disabled
	function automatic logic [31:0] view(input int i);
		logic [7:0] v;
		v = m[i];
		if (i == 0 && !en[EN_RT_CRC_BIT])
			v[4] = 1'b0;
		return {24'h0, v};
	endfunction
	task automatic cmp();
		logic [31:0] d;
		logic [1:0] r;
		logic x;
		for (int i = 0; i < 3; i++)
		begin
			i_host.rd({22'h0, IDX_CTRL_COMM + 8'(i), 2'h0}, d, r);
			chk(d, view(i));
			chk(32'(r), 32'(RESP_OKAY));
		end
		d = view(0);
		x = |({m[2], m[1], d[7:0]} & msk);
		chk(32'(irq), 32'(x));
		chk(32'(irq_n), 32'(!x));
	endtask
	// One-cycle detector burst, model sets gated flags
	task automatic fire(input logic [14:0] e);
		int r;
		int k;
		ev <= e;
		@(posedge ref_clk);
		ev <= '0;
		for (int b = 0; b < 15; b++)
		begin
			r = b > 9 ? 0 : b > 5 ? 1 : 2;
			k = b > 9 ? b - 10 : b > 5 ? b - 6 : b + 2;
			if (e[b] && (eb[b] < 0 || en[eb[b]]))
				m[r][k] = 1'b1;
		end
		@(posedge ref_clk);
	endtask
	task automatic wreg(input logic [7:0] i, input logic [31:0] d,
		input logic [1:0] x);
		logic [1:0] r;
		i_host.wr({22'h0, i, 2'h0}, d, r);
		chk(32'(r), 32'(x));
		if (i == IDX_ENABLE)
			en = d[5:0];
		if (i == IDX_MASK)
			msk = d[23:0];
		if (i >= IDX_CTRL_COMM && i <= IDX_INT_FAULT)
			m[i - IDX_CTRL_COMM] &= ~d[7:0];
		m[0][3:1] |= {ev.interrupt_pin_fault, ev.thermal_shutdown_fault,
			ev.rail_tag_fault};
		m[2][5] |= ev.reset_out_readback_fault;
	endtask
	task automatic results();
		if (errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		// Reset state, then random bursts, enables and clears
		cmp();
		repeat (30)
		begin
			wreg(IDX_ENABLE, $random(seed), RESP_OKAY);
			fire(15'($random(seed)));
			cmp();
			for (int i = 0; i < 3; i++)
				wreg(IDX_CTRL_COMM + 8'(i), $random(seed), RESP_OKAY);
			cmp();
		end
		// Held conditions keep flags until they go away
		wreg(IDX_ENABLE, 32'h3F, RESP_OKAY);
		for (int j = 0; j < 2; j++)
		begin
			ev <= (j == 0) ? 15'h3808 : 15'h0;
			@(posedge ref_clk);
			wreg(IDX_CTRL_COMM, 32'hFF, RESP_OKAY);
			wreg(IDX_INT_FAULT, 32'hFF, RESP_OKAY);
			cmp();
		end
		// Masked event keeps the interrupt quiet until unmasked
		wreg(IDX_MASK, 32'h0, RESP_OKAY);
		fire(15'h0100);
		cmp();
		wreg(IDX_MASK, 32'hFFFFFF, RESP_OKAY);
		cmp();
		wreg(IDX_TEST_LOAD, 32'hFF, RESP_OKAY);
		cmp();
		// Unmapped place answers with an error and no data
		wreg(8'h40, 32'hFF, RESP_SLVERR);
		i_host.rd(32'h0, d, r);
		chk(32'(r), 32'(RESP_SLVERR));
		chk(d, 32'h0);
		results();
	end
endmodule
